//--- hw/mel_map.vh
`ifndef MEL_MAP_VH
`define MEL_MAP_VH

// ----------------------------------------------------------------
// Register map (byte addresses on the APB side)
// ----------------------------------------------------------------
`define MEL_OFS_CTRL      8'h00
`define MEL_OFS_STATUS    8'h04

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define MEL_CTRL_DEV_LSB  0
`define MEL_CTRL_DEV_MSB  1
`define MEL_CTRL_RAM_BIT  2
`define MEL_CTRL_RST_VAL  32'h0000_0000

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define MEL_STAT_ADDR_LSB 0
`define MEL_STAT_ADDR_MSB 15
`define MEL_STAT_SR_LSB   16
`define MEL_STAT_SR_MSB   23
`define MEL_STAT_MODE_LSB 24
`define MEL_STAT_MODE_MSB 26
`define MEL_STAT_SIM_BIT  27
`define MEL_STAT_RST_BIT  28

// ----------------------------------------------------------------
// Mode codes on the three mode lines
// ----------------------------------------------------------------
`define MEL_MODE_INC      3'h0
`define MEL_MODE_SHIFT    3'h1
`define MEL_MODE_WRITE    3'h2
`define MEL_MODE_SIM      3'h3
`define MEL_MODE_READ     3'h4

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define MEL_ADDR_RST      16'h0000
`define MEL_SR_RST        8'h00
`define MEL_ADDR_W        16
`define MEL_MEM_DEPTH     65536

`endif

//--- hw/mel_host_loader.v
`timescale 1ns/1ps
`default_nettype none
`include "mel_map.vh"

module mel_host_loader (
  // Clock and reset
  input  wire        sys_clk_i,
  input  wire        sys_rst_i,
  // APB slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  // Host parallel port pins
  input  wire        mode_sel_bit0_i,
  input  wire        mode_sel_bit1_i,
  input  wire        mode_sel_bit2_i,
  input  wire        device_strobe_1_i,
  input  wire        device_strobe_2_i,
  input  wire        device_strobe_3_i,
  input  wire        device_strobe_4_i,
  input  wire        host_data_n_i,
  output reg         host_dout_n_o,
  // Target reset clamp and indicator
  output wire        tgt_rst_o,
  output wire        tgt_rst_oe_n_o,
  output wire        led_o,
  // Target memory socket
  input  wire [15:0] tgt_addr_i,
  input  wire        tgt_ce_n_i,
  input  wire        tgt_oe_n_i,
  input  wire        tgt_we_n_i,
  input  wire [7:0]  tgt_data_i,
  output reg  [7:0]  tgt_data_o,
  output wire        tgt_data_oe_n_o
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Emulated memory; one array shared by host loader and target
  // Not cleared by reset, so a loaded image survives a host reset
  reg [7:0] mem [0:`MEL_MEM_DEPTH-1];

  reg [31:0] ctrl_r;
  reg [15:0] addr_r;
  reg [7:0]  sr_r;
  reg        sim_on_r;
  reg        rst_act_r;
  reg        rd_drive_r;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // First stage feeds only the second stage
  // The target bus is sampled as a word; this is safe only because the
  // socket holds address and data for several clocks around each access
  reg [2:0]  mode_s1_r;
  reg [2:0]  mode_s2_r;
  reg [3:0]  stb_s1_r;
  reg [3:0]  stb_s2_r;
  reg        din_s1_r;
  reg        din_s2_r;
  reg [15:0] ta_s1_r;
  reg [15:0] ta_s2_r;
  reg [7:0]  td_s1_r;
  reg [7:0]  td_s2_r;
  reg [2:0]  tc_s1_r;
  reg [2:0]  tc_s2_r;

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mode_s1_r <= 3'h0;
      mode_s2_r <= 3'h0;
      stb_s1_r  <= 4'h0;
      stb_s2_r  <= 4'h0;
      din_s1_r  <= 1'h1;
      din_s2_r  <= 1'h1;
      ta_s1_r   <= 16'h0000;
      ta_s2_r   <= 16'h0000;
      td_s1_r   <= 8'h00;
      td_s2_r   <= 8'h00;
      tc_s1_r   <= 3'h7;
      tc_s2_r   <= 3'h7;
    end else begin
      mode_s1_r <= {mode_sel_bit2_i, mode_sel_bit1_i, mode_sel_bit0_i};
      mode_s2_r <= mode_s1_r;
      stb_s1_r  <= {device_strobe_4_i, device_strobe_3_i,
                    device_strobe_2_i, device_strobe_1_i};
      stb_s2_r  <= stb_s1_r;
      din_s1_r  <= host_data_n_i;
      din_s2_r  <= din_s1_r;
      ta_s1_r   <= tgt_addr_i;
      ta_s2_r   <= ta_s1_r;
      td_s1_r   <= tgt_data_i;
      td_s2_r   <= td_s1_r;
      tc_s1_r   <= {tgt_we_n_i, tgt_oe_n_i, tgt_ce_n_i};
      tc_s2_r   <= tc_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Strobe selection and edge detection
  // ----------------------------------------------------------------
  // Pick the strobe that matches this unit's device number
  // Changing the device number while a strobe is high could fake an
  // edge, yet the number is rewritten on any control write, whatever the strobes are doing
  wire [1:0] dev_sel  = ctrl_r[`MEL_CTRL_DEV_MSB:`MEL_CTRL_DEV_LSB];
  wire       ram_type = ctrl_r[`MEL_CTRL_RAM_BIT];
  wire       stb      = stb_s2_r[dev_sel];
  reg        stb_d_r;
  wire       stb_rise = stb & ~stb_d_r;
  wire       stb_fall = ~stb & stb_d_r;

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      stb_d_r <= 1'b0;
    end else begin
      stb_d_r <= stb;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // One compare shared by every mode flag; a full three-bit match keeps
  // the spare codes from aliasing onto a defined mode
  function mel_mode_is (
    input [2:0] cur,
    input [2:0] code
  );
    mel_mode_is = (cur == code);
  endfunction

  wire [2:0] mode     = mode_s2_r;
  wire       m_inc    = mel_mode_is(mode, `MEL_MODE_INC);
  wire       m_shift  = mel_mode_is(mode, `MEL_MODE_SHIFT);
  wire       m_write  = mel_mode_is(mode, `MEL_MODE_WRITE);
  wire       m_sim    = mel_mode_is(mode, `MEL_MODE_SIM);
  wire       m_read   = mel_mode_is(mode, `MEL_MODE_READ);
  // Codes 101..111 match none of the above and so act on nothing

  // ----------------------------------------------------------------
  // Address counter
  // ----------------------------------------------------------------
  reg [15:0] addr_nxt;

  // Only the strobe in modes 0 and 3 touches it, so it keeps its value
  // across every other mode change
  always @* begin
    addr_nxt = addr_r;
    if (m_sim && stb) begin
      addr_nxt = `MEL_ADDR_RST;
    end else if (m_inc && stb_rise) begin
      addr_nxt = addr_r + 16'h0001;
    end
  end

  // The counter wraps from FFFF to 0; a host that overshoots must clear
  // it in mode 3 and count up again
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      addr_r <= `MEL_ADDR_RST;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Shift register and serial output
  // ----------------------------------------------------------------
  // Data enters on the falling edge and the output moves on the rising
  // edge, so the host always samples a settled bit after its strobe
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sr_r          <= `MEL_SR_RST;
      host_dout_n_o <= 1'b1;
    end else begin
      if (m_shift && stb_fall) begin
        sr_r <= {sr_r[6:0], ~din_s2_r};
      end else if (m_read && stb_rise) begin
        sr_r <= mem[addr_r];
      end
      // Outside these modes the byte stays put
      if (m_shift && stb_rise) begin
        host_dout_n_o <= ~sr_r[7];
      end
    end
  end

  // ----------------------------------------------------------------
  // Simulation state and target reset clamp
  // ----------------------------------------------------------------
  reg sim_on_nxt;

  // Target is only served after the entry strobe; leaving mode 3 ends it
  always @* begin
    sim_on_nxt = sim_on_r;
    if (!m_sim) begin
      sim_on_nxt = 1'h0;
    end else if (stb) begin
      sim_on_nxt = 1'h1;
    end
  end

  // The clamp follows the mode alone: a target that fetches before the
  // entry strobe finds nothing driven on its data bus
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sim_on_r  <= 1'b0;
      rst_act_r <= 1'b1;
    end else begin
      rst_act_r <= ~m_sim;
      sim_on_r  <= sim_on_nxt;
    end
  end

  // Open collector: drive low when active, release otherwise
  assign tgt_rst_o      = 1'b0;
  assign tgt_rst_oe_n_o = ~rst_act_r;
  assign led_o          = rst_act_r;

  // ----------------------------------------------------------------
  // Target memory access
  // ----------------------------------------------------------------
  // Socket pins pass two flip-flops, so read data trails the address by
  // about three clocks; this trades access time for a single clock domain
  // and suits only slow targets
  wire tce_n = tc_s2_r[0];
  wire toe_n = tc_s2_r[1];
  wire twe_n = tc_s2_r[2];
  reg  twe_d_r;
  // A write commits on the trailing edge of the write pulse, when
  // address and data have long been stable at the socket
  wire twe_end = twe_n & ~twe_d_r;
  // Chip enable is not evaluated for RAM types
  wire t_rd    = sim_on_r & ~toe_n & (ram_type | ~tce_n);
  wire t_wr    = sim_on_r & ram_type & twe_end;

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      twe_d_r    <= 1'b1;
      rd_drive_r <= 1'b0;
      tgt_data_o <= 8'h00;
    end else begin
      twe_d_r    <= twe_n;
      rd_drive_r <= t_rd;
      tgt_data_o <= mem[ta_s2_r];
    end
  end

  assign tgt_data_oe_n_o = ~rd_drive_r;

  // Single write port; host and target writes never coincide since the
  // host path needs mode 2 and the target path needs mode 3
  always @(posedge sys_clk_i) begin
    if (m_write && stb_rise) begin
      mem[addr_r] <= sr_r;
    end else if (t_wr) begin
      mem[ta_s2_r] <= td_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Zero wait states; unmapped addresses answer with an error
  // Status is read only: a write to it completes without error and is
  // dropped
  wire apb_acc  = psel_i & penable_i;
  wire hit_ctrl = (paddr_i == `MEL_OFS_CTRL);
  wire hit_stat = (paddr_i == `MEL_OFS_STATUS);

  assign pready_o  = 1'b1;
  assign pslverr_o = apb_acc & ~hit_ctrl & ~hit_stat;

  // Control register: device number and memory type
  // Only the three defined bits are kept; the rest read back as zero
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ctrl_r <= `MEL_CTRL_RST_VAL;
    end else if (apb_acc && pwrite_i && hit_ctrl) begin
      ctrl_r <= {29'h0, pwdata_i[2:0]};
    end
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  reg  [31:0] rdata_nxt;
  wire        apb_setup = psel_i & ~penable_i;

  // Read mux
  always @* begin
    rdata_nxt = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata_nxt = ctrl_r;
    end else if (hit_stat) begin
      rdata_nxt[`MEL_STAT_ADDR_MSB:`MEL_STAT_ADDR_LSB] = addr_r;
      rdata_nxt[`MEL_STAT_SR_MSB:`MEL_STAT_SR_LSB]     = sr_r;
      rdata_nxt[`MEL_STAT_MODE_MSB:`MEL_STAT_MODE_LSB] = mode;
      rdata_nxt[`MEL_STAT_SIM_BIT]                     = sim_on_r;
      rdata_nxt[`MEL_STAT_RST_BIT]                     = rst_act_r;
    end
  end

  // The word is taken at the end of the setup phase, so read data comes
  // from a flip-flop yet stands for the whole single-cycle access phase;
  // status is therefore one clock old when the host sees it
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_o <= rdata_nxt;
    end
  end

endmodule

`default_nettype wire

//--- tb/mel_host_loader_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mel_host_loader_assertions (
  input wire logic       sys_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       psel_i,
  input wire logic       penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic       pready_o,
  input wire logic       pslverr_o,
  input wire logic       mode_sel_bit0_i,
  input wire logic       mode_sel_bit1_i,
  input wire logic       mode_sel_bit2_i,
  input wire logic       host_dout_n_o,
  input wire logic       tgt_rst_o,
  input wire logic       tgt_rst_oe_n_o,
  input wire logic       led_o,
  input wire logic       tgt_data_oe_n_o
);
  wire [2:0] mode = {mode_sel_bit2_i, mode_sel_bit1_i, mode_sel_bit0_i};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Five steady cycles cover the three-clock pin latency with margin
  led_follow_a: assert property (led_o == !tgt_rst_oe_n_o)
    else $error("led disagrees with reset clamp");
  rst_low_a: assert property (tgt_rst_o == 1'b0)
    else $error("reset drive value not low");
  clamp_held_a: assert property ((mode != 3'h3) [*5] |-> !tgt_rst_oe_n_o)
    else $error("reset clamp released outside simulation");
  clamp_free_a: assert property ((mode == 3'h3) [*5] |-> tgt_rst_oe_n_o)
    else $error("reset clamp held in simulation");
  no_drive_a: assert property ((mode != 3'h3) [*5] |-> tgt_data_oe_n_o)
    else $error("target data driven outside simulation");
  dout_cause_a: assert property (!$stable(host_dout_n_o) |-> $past(mode, 3) == 3'h1)
    else $error("serial out moved outside shift mode");
  apb_ready_a: assert property (psel_i && penable_i |-> pready_o)
    else $error("apb access not ready");
  apb_err_a: assert property (psel_i && penable_i |->
    pslverr_o == (paddr_i != 8'h00 && paddr_i != 8'h04))
    else $error("apb error flag wrong");
endmodule
bind mel_host_loader mel_host_loader_assertions u_chk (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .mode_sel_bit0_i(mode_sel_bit0_i), .mode_sel_bit1_i(mode_sel_bit1_i),
  .mode_sel_bit2_i(mode_sel_bit2_i), .host_dout_n_o(host_dout_n_o), .tgt_rst_o(tgt_rst_o),
  .tgt_rst_oe_n_o(tgt_rst_oe_n_o), .led_o(led_o), .tgt_data_oe_n_o(tgt_data_oe_n_o));
`default_nettype wire

//--- tb/mel_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mel_host_model (
  output logic [2:0] mode_o,
  output logic [3:0] stb_o,
  output logic       data_n_o,
  input  wire logic  dout_n_i
);
  // Port lines idle with every strobe low
  initial begin
    mode_o = 3'h0;
    stb_o = 4'h0;
    data_n_o = 1'b1;
  end
  // Mode moves only with strobes low, then settles half a link period
  task automatic set_mode(input logic [2:0] m);
    mode_o = m;
    #62.5;
  endtask
  // One 125 ns strobe period; serial out read late in the high phase.
  // Data is held well past the fall, since the fall is what takes it in
  task automatic pulse(input int s, input logic d, output logic o);
    data_n_o = d;
    #30 stb_o[s] = 1'b1;
    #60 o = ~dout_n_i;
    #2.5 stb_o[s] = 1'b0;
    #32.5;
  endtask
  // Byte out bit 7 first, inverted on the line; returns the bits echoed back
  task automatic xfer(input logic [7:0] b, output logic [7:0] o);
    for (int i = 7; i >= 0; i--) pulse(0, ~b[i], o[i]);
  endtask
endmodule
`default_nettype wire

//--- tb/mel_host_loader_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mel_host_loader_tb;
  logic        sys_clk_i = 0, sys_rst_i, psel, pen, pwr, b, e;
  logic [7:0]  paddr, tdi, tdo, q;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] taddr;
  logic        pready, perr, dout_n, rst_o, rst_oe_n, led, toe_n, ce_n, oe_n, we_n;
  wire  [2:0]  mode;
  wire  [3:0]  stb;
  wire         data_n;
  int          failures = 0, compares = 0, cyc = 0;
  mel_host_loader u_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(perr), .mode_sel_bit0_i(mode[0]), .mode_sel_bit1_i(mode[1]),
    .mode_sel_bit2_i(mode[2]), .device_strobe_1_i(stb[0]), .device_strobe_2_i(stb[1]),
    .device_strobe_3_i(stb[2]), .device_strobe_4_i(stb[3]), .host_data_n_i(data_n),
    .host_dout_n_o(dout_n), .tgt_rst_o(rst_o), .tgt_rst_oe_n_o(rst_oe_n), .led_o(led),
    .tgt_addr_i(taddr), .tgt_ce_n_i(ce_n), .tgt_oe_n_i(oe_n), .tgt_we_n_i(we_n),
    .tgt_data_i(tdi), .tgt_data_o(tdo), .tgt_data_oe_n_o(toe_n));
  mel_host_model u_host (.mode_o(mode), .stb_o(stb), .data_n_o(data_n), .dout_n_i(dout_n));
  initial forever #5 sys_clk_i = ~sys_clk_i;
  // Hang guard: the whole run needs well under 5000 cycles
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      test_done;
    end
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      failures++;
      $display("ERROR %s expected %h got %h", n, x, g);
    end
  endtask
  // APB transfer; read data and error taken at the edge where pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    pen <= 1;
    do @(posedge sys_clk_i); while (pready !== 1'b1);
    r = prdata;
    e = perr;
    psel <= 0;
    pen <= 0;
  endtask
  // Status read after the pin synchronisers have settled
  task automatic stat;
    repeat (5) @(posedge sys_clk_i);
    apb(0, 8'h04, 32'h0);
  endtask
  // Socket access held for eight clocks; read data sampled while still driven
  task automatic tgt(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    taddr <= a;
    tdi <= d;
    ce_n <= 0;
    oe_n <= w;
    we_n <= !w;
    repeat (8) @(posedge sys_clk_i);
    q = tdo;
    e = toe_n;
    ce_n <= 1;
    oe_n <= 1;
    we_n <= 1;
    repeat (8) @(posedge sys_clk_i);
  endtask
  task automatic t_reset;
    apb(0, 8'h00, 32'h0);
    chk("ctrl", 32'h0, r);
    stat;
    chk("status", 32'h1000_0000, r & 32'h1FFF_FFFF);
    chk("clamp", 32'h0, rst_oe_n);
    chk("led", 32'h1, led);
    chk("rst_o", 32'h0, rst_o);
    $display("t_reset done");
  endtask
  // Clear, then count with device two selected once and device one after
  task automatic t_addr;
    u_host.set_mode(3'h3);
    u_host.pulse(0, 1'b1, b);
    apb(1, 8'h00, 32'h1);
    u_host.set_mode(3'h0);
    u_host.pulse(1, 1'b1, b);
    u_host.pulse(0, 1'b1, b);
    apb(1, 8'h00, 32'h0);
    repeat (3) u_host.pulse(0, 1'b1, b);
    u_host.pulse(1, 1'b1, b);
    u_host.set_mode(3'h1);
    stat;
    chk("addr", 32'h0100_0004, r & 32'h07FF_FFFF);
    $display("t_addr done");
  endtask
  task automatic t_data;
    u_host.xfer(8'h35, q);
    stat;
    chk("shifter", 32'h35, r[23:16]);
    u_host.set_mode(3'h2);
    u_host.pulse(0, 1'b1, b);
    u_host.set_mode(3'h1);
    u_host.xfer(8'hCA, q);
    chk("echo", 32'h35, q);
    for (int m = 5; m < 8; m++) begin
      u_host.set_mode(3'(m));
      u_host.pulse(0, 1'b0, b);
    end
    stat;
    chk("idle codes", 32'hCA0004, r[23:0]);
    u_host.set_mode(3'h4);
    u_host.pulse(0, 1'b1, b);
    u_host.set_mode(3'h1);
    u_host.xfer(8'h00, q);
    chk("readback", 32'h35, q);
    // Fill: zero byte written at 5 and 6 without shifting again
    repeat (2) begin
      u_host.set_mode(3'h0);
      u_host.pulse(0, 1'b1, b);
      u_host.set_mode(3'h2);
      u_host.pulse(0, 1'b1, b);
    end
    $display("t_data done");
  endtask
  task automatic t_sim;
    u_host.set_mode(3'h3);
    repeat (5) @(posedge sys_clk_i);
    chk("released", 32'h1, rst_oe_n);
    chk("led off", 32'h0, led);
    u_host.pulse(0, 1'b1, b);
    stat;
    chk("sim", 32'h0B00_0000, r & 32'h1FFF_FFFF);
    tgt(0, 16'h0004, 8'h00);
    chk("rom read", 32'h35, q);
    chk("drive", 32'h0, e);
    tgt(1, 16'h0005, 8'hA5);
    tgt(0, 16'h0005, 8'h00);
    chk("rom write", 32'h00, q);
    tgt(0, 16'h0006, 8'h00);
    chk("fill", 32'h00, q);
    apb(1, 8'h00, 32'h4);
    tgt(1, 16'h0005, 8'hA5);
    tgt(0, 16'h0005, 8'h00);
    chk("ram write", 32'hA5, q);
    apb(1, 8'h08, 32'h0);
    chk("slverr", 32'h1, e);
    u_host.set_mode(3'h0);
    repeat (5) @(posedge sys_clk_i);
    chk("clamp back", 32'h0, rst_oe_n);
    $display("t_sim done");
  endtask
  task automatic test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    sys_rst_i = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    taddr = 16'h0000;
    tdi = 8'h00;
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    repeat (12) @(posedge sys_clk_i);
    sys_rst_i <= 0;
    repeat (3) @(posedge sys_clk_i);
    t_reset;
    t_addr;
    t_data;
    t_sim;
    test_done;
  end
endmodule
`default_nettype wire
